// >>> design/crf_pkg.sv
package crf_pkg;
  localparam int VW     = 25;
  localparam int AW     = 8;
  localparam int CNT_W  = 10;
  localparam int PCT_W  = 7;

  localparam logic [AW-1:0] REG_CTRL     = 8'h00;
  localparam logic [AW-1:0] REG_INIT_OFS = 8'h04;
  localparam logic [AW-1:0] REG_TDC_DLY  = 8'h08;
  localparam logic [AW-1:0] REG_ACT_DLY  = 8'h0C;
  localparam logic [AW-1:0] REG_QR_WIDTH = 8'h10;
  localparam logic [AW-1:0] REG_STATUS   = 8'h14;
  localparam logic [AW-1:0] REG_IOUT     = 8'h18;
  localparam logic [AW-1:0] REG_TARGET   = 8'h1C;

  localparam int CTRL_CORE_EXT = 0;
  localparam int CTRL_COMP_EXT = 1;
  localparam int CTRL_PCT_LSB  = 8;

  localparam logic [31:0] CTRL_RST     = 32'h0000_6400;
  localparam logic [31:0] INIT_OFS_RST = 32'h0000_0000;
  localparam logic [15:0] TDC_DLY_RST  = 16'h00C8;
  localparam logic [15:0] ACT_DLY_RST  = 16'h00C8;
  localparam logic [15:0] QR_WIDTH_RST = 16'h0040;

  localparam int CLK_MHZ        = 200;
  localparam int OV_FILTER_NS   = 1000;
  localparam int UV_FILTER_NS   = 3000;
  localparam int SUPPLY_LOCKOUT_FILTER_NS = 3000;
  localparam logic [CNT_W-1:0] OV_CYC   = CNT_W'((OV_FILTER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] UV_CYC   = CNT_W'((UV_FILTER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] SUPPLY_LOCKOUT_CYC = CNT_W'((SUPPLY_LOCKOUT_FILTER_NS * CLK_MHZ + 999) / 1000);

  localparam logic signed [VW-1:0] OFS_DISABLE_UV = 25'sd300000;
  localparam logic signed [VW-1:0] EXT_OFS_BASE_UV = 25'sd1200000;
  localparam logic signed [VW-1:0] CURRENT_MONITOR_PIN_OFFSET_UV = 25'sd640000;
  localparam logic signed [VW-1:0] CURRENT_MONITOR_PIN_FULL_UV   = 25'sd3193750;
  localparam logic signed [VW-1:0] ADC_LSB_UV     = 25'sd6250;
  localparam logic [8:0]           ADC_MAX_CODE   = 9'h1FF;
  localparam logic signed [VW-1:0] OV_FLOOR_UV    = 25'sd900000;
  localparam logic signed [VW-1:0] OV_MARGIN_UV   = 25'sd325000;
  localparam logic signed [VW-1:0] UV_MARGIN_UV   = 25'sd500000;
  localparam logic signed [VW-1:0] NV_LEVEL_UV    = 25'sd0;
  localparam logic [1:0]           MAX_PHASES     = 2'h3;

  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_WAIT = 2'b01,
    OC_OFF  = 2'b10
  } crf_oc_t;

  typedef struct packed {
    logic hs_force_off;
    logic ls_force_on;
    logic ls_force_off;
  } crf_gate_t;
endpackage

// >>> design/crf_core.sv
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
module crf_core (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [crf_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [crf_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   enable_pin,
  input  wire logic                   config_strap_a,
  input  wire logic                   config_strap_b,
  input  wire logic                   supply_ok,
  input  wire logic                   quick_resp_trig,
  input  wire logic                   dynamic_voltage_step_up,
  input  wire logic                   dynamic_voltage_step_down,
  input  wire logic                   diode_emulation_req,
  input  wire logic [crf_pkg::VW-1:0] core_offset_input,
  input  wire logic [crf_pkg::VW-1:0] companion_offset_input,
  input  wire logic [crf_pkg::VW-1:0] output_voltage_sense,
  input  wire logic [crf_pkg::VW-1:0] voltage_code,
  input  wire logic [crf_pkg::VW-1:0] reference_uv,
  input  wire logic [crf_pkg::VW-1:0] droop_uv,
  input  wire logic [crf_pkg::VW-1:0] isum_avg_uv,
  input  wire logic [crf_pkg::VW-1:0] isum_cyc_uv,
  input  wire logic [1:0]             phase_req,
  output crf_pkg::crf_gate_t          gate,
  output logic [1:0]                  phase_count,
  output logic                        load_line_hold,
  output logic [1:0]                  dynamic_voltage_step_comp,
  output logic                        ramp_internal,
  output logic                        ramp_strap,
  output logic                        qr_pulse,
  output logic [crf_pkg::VW-1:0]      core_target_uv,
  output logic [crf_pkg::VW-1:0]      companion_offset_uv,
  output logic [crf_pkg::VW-1:0]      current_monitor_pin,
  output logic                        companion_soft_shutdown,
  output logic                        overcurrent_alert_n
);
  import crf_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Pin synchronisers
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw, pin_m, pin_s;
  assign pin_raw = {diode_emulation_req, dynamic_voltage_step_down, dynamic_voltage_step_up, quick_resp_trig,
                    supply_ok, config_strap_b, config_strap_a, enable_pin};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_m[gi] <= 1'b0;
          pin_s[gi] <= 1'b0;
        end else begin
          pin_m[gi] <= pin_raw[gi];
          pin_s[gi] <= pin_m[gi];
        end
      end
    end
  endgenerate

  logic en_s, strap_a_s, strap_b_s, sup_s, qr_s, up_s, down_s, dem_s;
  assign {dem_s, down_s, up_s, qr_s, sup_s, strap_b_s, strap_a_s, en_s} = pin_s;

  logic en_q, qr_q, en_rise, qr_rise;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
      qr_q <= 1'b0;
    end else begin
      en_q <= en_s;
      qr_q <= qr_s;
    end
  end
  assign en_rise = en_s & ~en_q;
  assign qr_rise = qr_s & ~qr_q;

  // Registers
  logic [31:0] ctrl, init_ofs;
  logic [15:0] tdc_dly, act_dly, qr_width;
  logic [8:0]  iout;
  logic        aw_hold, w_hold;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write, wr_ok;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction

  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
  assign wr_ok = aw_addr inside {REG_CTRL, REG_INIT_OFS, REG_TDC_DLY, REG_ACT_DLY,
                                 REG_QR_WIDTH};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      init_ofs <= INIT_OFS_RST;
      tdc_dly <= TDC_DLY_RST;
      act_dly <= ACT_DLY_RST;
      qr_width <= QR_WIDTH_RST;
    end else if (do_write) begin
      unique case (aw_addr)
        REG_CTRL:     ctrl <= merge(ctrl, w_data, w_strb);
        REG_INIT_OFS: init_ofs <= merge(init_ofs, w_data, w_strb);
        REG_TDC_DLY:  tdc_dly <= 16'(merge({16'h0, tdc_dly}, w_data, w_strb));
        REG_ACT_DLY:  act_dly <= 16'(merge({16'h0, act_dly}, w_data, w_strb));
        REG_QR_WIDTH: qr_width <= 16'(merge({16'h0, qr_width}, w_data, w_strb));
        default: ;
      endcase
    end
  end

  // Fault state
  logic ov_latch, uv_latch, supply_lockout, negative_voltage_guard;
  logic sustained_overcurrent_trip, spike_overcurrent_trip, init_ok;
  crf_oc_t oc_st, next_oc_st;
  logic [31:0] status_word;
  assign status_word = {18'h0, phase_count, dynamic_voltage_step_comp, ramp_internal, qr_pulse,
                        ~overcurrent_alert_n, oc_st == OC_OFF, sustained_overcurrent_trip,
                        spike_overcurrent_trip, supply_lockout, negative_voltage_guard,
                        uv_latch, ov_latch};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        REG_CTRL:     s_axi_rdata <= ctrl;
        REG_INIT_OFS: s_axi_rdata <= init_ofs;
        REG_TDC_DLY:  s_axi_rdata <= {16'h0, tdc_dly};
        REG_ACT_DLY:  s_axi_rdata <= {16'h0, act_dly};
        REG_QR_WIDTH: s_axi_rdata <= {16'h0, qr_width};
        REG_STATUS:   s_axi_rdata <= status_word;
        REG_IOUT:     s_axi_rdata <= {23'h0, iout};
        REG_TARGET:   s_axi_rdata <= 32'(signed'(core_target_uv));
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Straps and offsets caught at enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_ok <= 1'b0;
      dynamic_voltage_step_comp <= 2'h0;
      ramp_strap <= 1'b0;
    end else if (en_rise) begin
      init_ok <= signed'(core_offset_input) >= OFS_DISABLE_UV;
      dynamic_voltage_step_comp <= {strap_b_s, strap_a_s};
      ramp_strap <= strap_a_s;
    end
  end

  // Regulation target
  logic ext_on;
  logic signed [VW-1:0] next_target;
  assign ext_on = ctrl[CTRL_CORE_EXT] & ctrl[CTRL_COMP_EXT];
  always_comb begin
    next_target = signed'(voltage_code) - signed'(droop_uv);
    if (init_ok) next_target = next_target + signed'(init_ofs[VW-1:0]);
    if (ext_on) next_target = next_target + signed'(core_offset_input) - EXT_OFS_BASE_UV;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_target_uv <= '0;
      companion_offset_uv <= '0;
    end else begin
      core_target_uv <= next_target;
      companion_offset_uv <= ext_on ? VW'(signed'(companion_offset_input) - EXT_OFS_BASE_UV)
                                    : '0;
    end
  end

  // Phase, ramp and quick response
  logic [15:0] qr_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_count <= MAX_PHASES;
      load_line_hold <= 1'b0;
      ramp_internal <= 1'b0;
      qr_cnt <= '0;
      qr_pulse <= 1'b0;
    end else begin
      if (up_s) phase_count <= MAX_PHASES;
      else if (!down_s) phase_count <= phase_req;
      load_line_hold <= up_s | down_s;
      ramp_internal <= dem_s & (phase_req < MAX_PHASES);
      if (qr_rise && qr_cnt == 16'h0) qr_cnt <= qr_width;
      else if (qr_cnt != 16'h0) qr_cnt <= qr_cnt - 16'h1;
      qr_pulse <= (qr_rise && qr_cnt == 16'h0) ? (qr_width != 16'h0) : (qr_cnt > 16'h1);
    end
  end

  // Current monitor and ADC
  logic signed [VW-1:0] next_current_monitor_pin;
  assign next_current_monitor_pin = signed'(isum_avg_uv) + CURRENT_MONITOR_PIN_OFFSET_UV;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_monitor_pin <= '0;
      iout <= '0;
    end else begin
      current_monitor_pin <= next_current_monitor_pin;
      if (next_current_monitor_pin <= NV_LEVEL_UV) iout <= 9'h0;
      else if (next_current_monitor_pin >= CURRENT_MONITOR_PIN_FULL_UV) iout <= ADC_MAX_CODE;
      else iout <= 9'(next_current_monitor_pin / ADC_LSB_UV);
    end
  end

  // Over-current detection
  logic [31:0] spike_thr, avg_scaled, tdc_thr;
  logic tdc_over, spike_over;
  logic [15:0] tdc_cnt, act_cnt;
  assign spike_thr = 32'(CURRENT_MONITOR_PIN_FULL_UV - CURRENT_MONITOR_PIN_OFFSET_UV);
  assign avg_scaled = 32'(isum_avg_uv) * 32'd100;
  assign tdc_thr = spike_thr * 32'(ctrl[CTRL_PCT_LSB +: PCT_W]);
  assign tdc_over = ~isum_avg_uv[VW-1] & (avg_scaled > tdc_thr);
  assign spike_over = ~isum_cyc_uv[VW-1] & (32'(isum_cyc_uv) > spike_thr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdc_cnt <= '0;
      sustained_overcurrent_trip <= 1'b0;
      spike_overcurrent_trip <= 1'b0;
    end else begin
      tdc_cnt <= tdc_over ? ((tdc_cnt == 16'hFFFF) ? tdc_cnt : tdc_cnt + 16'h1) : 16'h0;
      sustained_overcurrent_trip <= tdc_over & (tdc_cnt >= tdc_dly);
      spike_overcurrent_trip <= spike_over;
    end
  end

  always_comb begin
    next_oc_st = oc_st;
    unique case (oc_st)
      OC_IDLE: if (sustained_overcurrent_trip || spike_overcurrent_trip) next_oc_st = OC_WAIT;
      OC_WAIT: if (act_cnt >= act_dly) next_oc_st = (tdc_over || spike_over) ? OC_OFF : OC_IDLE;
      OC_OFF:  next_oc_st = OC_OFF;
      default: next_oc_st = OC_IDLE;
    endcase
    if (en_rise) next_oc_st = OC_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_st <= OC_IDLE;
      act_cnt <= '0;
      overcurrent_alert_n <= 1'b1;
    end else begin
      oc_st <= next_oc_st;
      act_cnt <= (oc_st == OC_WAIT) ? act_cnt + 16'h1 : 16'h0;
      overcurrent_alert_n <= next_oc_st == OC_IDLE;
    end
  end

  // Voltage protections
  logic signed [VW-1:0] ov_thr;
  logic ov_cond, uv_cond, lo_cond;
  logic [CNT_W-1:0] ov_cnt, uv_cnt, lo_cnt;
  assign ov_thr = (signed'(voltage_code) < OV_FLOOR_UV) ? OV_FLOOR_UV + OV_MARGIN_UV
                                                        : signed'(reference_uv) + OV_MARGIN_UV;
  assign ov_cond = signed'(output_voltage_sense) > ov_thr;
  assign uv_cond = en_s & (signed'(output_voltage_sense) <
                           signed'(reference_uv) - UV_MARGIN_UV);
  assign lo_cond = en_s & ~sup_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_cnt <= '0;
      uv_cnt <= '0;
      lo_cnt <= '0;
      ov_latch <= 1'b0;
      uv_latch <= 1'b0;
      supply_lockout <= 1'b0;
    end else begin
      ov_cnt <= (ov_cond && ov_cnt < OV_CYC) ? ov_cnt + 1'b1 : (ov_cond ? ov_cnt : '0);
      uv_cnt <= (uv_cond && uv_cnt < UV_CYC) ? uv_cnt + 1'b1 : (uv_cond ? uv_cnt : '0);
      lo_cnt <= (lo_cond && lo_cnt < SUPPLY_LOCKOUT_CYC) ? lo_cnt + 1'b1 : (lo_cond ? lo_cnt : '0);
      // A fault that trips in the enable cycle wins over the clear
      if (en_rise) begin
        ov_latch <= 1'b0;
        uv_latch <= 1'b0;
      end
      if (ov_cond && ov_cnt == OV_CYC - 1'b1) ov_latch <= 1'b1;
      if (uv_cond && uv_cnt == UV_CYC - 1'b1) uv_latch <= 1'b1;
      supply_lockout <= lo_cond & (lo_cnt >= SUPPLY_LOCKOUT_CYC - 1'b1);
    end
  end

  assign negative_voltage_guard = ov_latch &
                                  (signed'(output_voltage_sense) < NV_LEVEL_UV);

  // Gate control
  logic all_off;
  assign all_off = ~en_s | supply_lockout | uv_latch | (oc_st == OC_OFF);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate <= '{hs_force_off: 1'b1, ls_force_on: 1'b0, ls_force_off: 1'b1};
      companion_soft_shutdown <= 1'b0;
    end else begin
      gate.hs_force_off <= all_off | ov_latch;
      gate.ls_force_on <= ~all_off & ov_latch & ~negative_voltage_guard;
      gate.ls_force_off <= all_off | (ov_latch & negative_voltage_guard);
      companion_soft_shutdown <= ov_latch | uv_latch;
    end
  end

  init_ofs_a: assert property (en_rise && signed'(core_offset_input) < OFS_DISABLE_UV
    |=> !init_ok) else $error("initial offset not disabled");
  dynamic_voltage_step_up_a: assert property (up_s |=> phase_count == MAX_PHASES)
    else $error("step up did not force three phases");
  spike_alert_a: assert property (spike_over && oc_st == OC_IDLE && !en_rise ##1 !en_rise
    |=> !overcurrent_alert_n) else $error("spike did not raise alert");
  ov_filter_a: assert property ($rose(ov_latch) |-> $past(ov_cnt) == OV_CYC - 1'b1)
    else $error("over-voltage tripped without filter");
  uv_filter_a: assert property ($rose(uv_latch) |-> $past(uv_cnt) == UV_CYC - 1'b1)
    else $error("under-voltage tripped without filter");
  ov_gate_a: assert property (ov_latch && !all_off && !negative_voltage_guard
    |=> gate.ls_force_on && gate.hs_force_off) else $error("over-voltage gate wrong");
  nvp_gate_a: assert property (negative_voltage_guard |=> gate.ls_force_off && !gate.ls_force_on)
    else $error("negative guard left low side on");
  lockout_off_a: assert property (supply_lockout |=> gate.hs_force_off && gate.ls_force_off)
    else $error("lock-out left a switch on");
  sister_off_a: assert property ($rose(uv_latch) |=> companion_soft_shutdown)
    else $error("companion not shut down");
endmodule

// >>> verif/crf_stage.sv
module crf_stage (
  input  wire logic                   aclk,
  input  wire crf_pkg::crf_gate_t     gate,
  input  wire logic [crf_pkg::VW-1:0] setpoint,
  output logic [crf_pkg::VW-1:0]      sense
);
  timeunit 1ns;
  timeprecision 1ps;
  import crf_pkg::*;
  logic signed [VW-1:0] v = '0;
  assign sense = v;
  // Low-side on discharges the output below ground; all-off lets it drift back toward ground from either side
  always_ff @(posedge aclk) begin
    if (gate.ls_force_on) begin
      v <= (v > -25'sd100000) ? v - 25'sd20000 : v;
    end else if (gate.hs_force_off && gate.ls_force_off) begin
      v <= (v < 0) ? v + 25'sd15000 : ((v > 25'sd5000) ? v - 25'sd5000 : v);
    end else begin
      v <= setpoint;
    end
  end
endmodule

// >>> verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import crf_pkg::*;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp, phase_req, phase_count, dynamic_voltage_step_comp, rsp;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic          s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic          aclk, aresetn, enable_pin, config_strap_a, config_strap_b, supply_ok;
  logic          quick_resp_trig, dynamic_voltage_step_up, dynamic_voltage_step_down, diode_emulation_req, load_line_hold;
  logic          ramp_internal, ramp_strap, qr_pulse, companion_soft_shutdown;
  logic          overcurrent_alert_n;
  logic [VW-1:0] core_offset_input, companion_offset_input, output_voltage_sense;
  logic [VW-1:0] voltage_code, reference_uv, droop_uv, isum_avg_uv, isum_cyc_uv;
  logic [VW-1:0] core_target_uv, companion_offset_uv, current_monitor_pin, setpoint;
  crf_gate_t     gate;
  logic [31:0]   seed;
  int            fail_count, checks_done, n, k, i, vc, dr, io, co, cp;
  logic [7:0]    ra [5] = '{REG_CTRL, REG_INIT_OFS, REG_TDC_DLY, REG_ACT_DLY, REG_QR_WIDTH};
  logic [31:0]   rv [5] = '{CTRL_RST, INIT_OFS_RST, 32'(TDC_DLY_RST), 32'(ACT_DLY_RST),
                           32'(QR_WIDTH_RST)};

  crf_core i_crf_core (.*);
  crf_stage i_crf_stage (.aclk, .gate, .setpoint, .sense(output_voltage_sense));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic hit(input int s);
    case (s)
      0: return overcurrent_alert_n === 1'b0;
      1: return gate === 3'b101;
      2: return gate === 3'b110;
      4: return gate === 3'b000;
      5: return qr_pulse === 1'b1;
      default: return qr_pulse === 1'b0;
    endcase
  endfunction

  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask

  task automatic upto(input int s, input int lim);
    n = 0;
    while (!hit(s) && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // Enable cycle clears latched faults and captures the offset pin
  task automatic en();
    enable_pin <= 1'b0;
    cyc(8);
    enable_pin <= 1'b1;
    cyc(8);
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    cyc(20000);
    fail_count++;
    conclude();
  end

  initial begin
    seed = 32'h9;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, aresetn, enable_pin, config_strap_a,
     config_strap_b, quick_resp_trig, dynamic_voltage_step_up, dynamic_voltage_step_down, diode_emulation_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {core_offset_input, companion_offset_input, voltage_code, droop_uv} = '0;
    {isum_avg_uv, isum_cyc_uv} = '0;
    {s_axi_bready, s_axi_rready, supply_ok} = '1;
    s_axi_wstrb = 4'hF;
    reference_uv = 25'd1000000;
    setpoint = 25'd1000000;
    phase_req = 2'h3;
    cyc(10);
    aresetn <= 1'b1;
    // Register reset values and refused accesses
    for (i = 0; i < 5; i++) begin
      rdr(ra[i]);
      chk("reset value", rv[i], rd);
    end
    rdr(8'h20);
    chk("unmapped resp", 2'b10, rsp);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    chk("read-only resp", 2'b10, rsp);
    // Regulation target and offsets
    vc = 900000 + int'(xs() % 400000);
    dr = int'(xs() % 50000);
    io = int'(xs() % 100000) - 50000;
    co = 1200000 + int'(xs() % 200000);
    cp = 1200000 + int'(xs() % 200000);
    k = int'(xs() % 4);
    config_strap_a <= k[0];
    config_strap_b <= k[1];
    voltage_code <= 25'(vc);
    droop_uv <= 25'(dr);
    core_offset_input <= 25'(co);
    companion_offset_input <= 25'(cp);
    wr(REG_INIT_OFS, 32'(io));
    wr(REG_CTRL, 32'h0000_6403);
    en();
    rdr(REG_TARGET);
    chk("target", vc - dr + io + co - 1200000, rd);
    chk("companion offset", 32'(25'(cp - 1200000)), 32'(companion_offset_uv));
    chk("dynamic_voltage_step comp", k, dynamic_voltage_step_comp);
    chk("ramp strap", k[0], ramp_strap);
    core_offset_input <= 25'd200000;
    en();
    rdr(REG_TARGET);
    chk("target", vc - dr - 1000000, rd);
    wr(REG_CTRL, 32'h0000_6400);
    cyc(4);
    rdr(REG_TARGET);
    chk("target", vc - dr, rd);
    // Current monitor and its converter
    for (i = 0; i < 4; i++) begin
      k = (i == 0) ? 510 : 103 + int'(xs() % 407);
      isum_avg_uv <= 25'(k * 6250 - 640000);
      cyc(8);
      chk("monitor pin", k * 6250, 32'(current_monitor_pin));
      rdr(REG_IOUT);
      chk("iout", k, rd);
    end
    isum_avg_uv <= '0;
    // Quick response pulse
    wr(REG_QR_WIDTH, 32'd10);
    quick_resp_trig <= 1'b1;
    cyc(3);
    quick_resp_trig <= 1'b0;
    upto(5, 10);
    upto(6, 100);
    chk("qr width", 10, n);
    // Voltage steps and ramp selection
    phase_req <= 2'h1;
    diode_emulation_req <= 1'b1;
    dynamic_voltage_step_up <= 1'b1;
    cyc(8);
    chk("phase up", 3, phase_count);
    chk("hold up", 1, load_line_hold);
    dynamic_voltage_step_up <= 1'b0;
    cyc(8);
    chk("ramp dem", 1, ramp_internal);
    k = int'(phase_count);
    dynamic_voltage_step_down <= 1'b1;
    cyc(2);
    phase_req <= 2'h2;
    cyc(6);
    chk("phase down", k, phase_count);
    chk("hold down", 1, load_line_hold);
    dynamic_voltage_step_down <= 1'b0;
    diode_emulation_req <= 1'b0;
    phase_req <= 2'h3;
    cyc(8);
    chk("ramp ccm", 0, ramp_internal);
    // Spike over-current, short then sustained
    wr(REG_ACT_DLY, 32'd30);
    isum_cyc_uv <= 25'd2600000;
    upto(0, 10);
    chk("spike alert", 1, n <= 5);
    cyc(6);
    isum_cyc_uv <= '0;
    cyc(50);
    chk("no action", 0, 32'(gate));
    en();
    isum_cyc_uv <= 25'd2600000;
    upto(1, 60);
    chk("oc action", 1, n >= 26 && n <= 38);
    isum_cyc_uv <= '0;
    en();
    chk("oc cleared", 0, 32'(gate));
    // Time-qualified over-current at half the spike level
    wr(REG_CTRL, 32'h0000_3200);
    wr(REG_TDC_DLY, 32'd40);
    isum_avg_uv <= 25'd1400000;
    cyc(20);
    isum_avg_uv <= 25'd1000000;
    upto(0, 40);
    chk("tdc early", 40, n);
    isum_avg_uv <= 25'd1400000;
    upto(0, 60);
    chk("tdc delay", 1, n >= 40 && n <= 46);
    isum_avg_uv <= '0;
    wr(REG_CTRL, 32'h0000_6400);
    en();
    // Over-voltage, negative guard
    setpoint <= 25'd1250000;
    cyc(250);
    chk("ov ref", 0, 32'(gate));
    voltage_code <= 25'd800000;
    setpoint <= 25'd1000000;
    cyc(10);
    setpoint <= 25'd1250000;
    cyc(150);
    setpoint <= 25'd1000000;
    cyc(10);
    chk("ov filter", 0, 32'(gate));
    setpoint <= 25'd1250000;
    upto(2, 260);
    chk("ov delay", 1, n >= 199 && n <= 206);
    chk("ov soft", 1, companion_soft_shutdown);
    upto(1, 200);
    chk("neg guard", 1, n < 200);
    upto(2, 50);
    chk("ov resume", 1, n < 50);
    setpoint <= 25'd1000000;
    cyc(100);
    chk("ov kept", 1, gate.hs_force_off);
    rdr(REG_STATUS);
    chk("status ov", 1, rd[0]);
    en();
    // Under-voltage
    setpoint <= 25'd400000;
    cyc(400);
    setpoint <= 25'd1000000;
    cyc(10);
    chk("uv filter", 0, 32'(gate));
    setpoint <= 25'd400000;
    upto(1, 700);
    chk("uv delay", 1, n >= 599 && n <= 608);
    chk("uv soft", 1, companion_soft_shutdown);
    setpoint <= 25'd1000000;
    en();
    // Supply lock-out
    supply_ok <= 1'b0;
    upto(1, 700);
    chk("lockout delay", 1, n >= 599 && n <= 610);
    supply_ok <= 1'b1;
    upto(4, 12);
    chk("lockout release", 1, n < 12);
    conclude();
  end
endmodule
